/* File: rtl/prs_seq.sv */
// power-up reset sequencer with apb register access
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module prs_seq #(
  parameter int unsigned DELAY_CYCLES = prs_pkg::DLY_CYC,
  parameter int unsigned OST_CYCLES = prs_pkg::OST_CYC,
  parameter int unsigned BOD_CYCLES = prs_pkg::BOD_MIN_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [prs_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // supply monitors and pins
  input wire logic por_active,
  input wire logic brown_out_cmp,
  input wire logic external_reset_pin_n,
  input wire logic osc_tick,
  // configuration
  input wire prs_pkg::prs_osc_t osc_mode,
  input wire logic delay_timer_disable_cfg,
  input wire logic brown_out_enable_cfg,
  // core events
  input wire logic wdt_timeout,
  input wire logic wake_irq,
  input wire logic global_irq_enable,
  // core control
  output logic core_reset_n,
  output logic core_stall,
  output logic pc_load,
  output prs_pkg::prs_pc_t pc_action
);
  import prs_pkg::*;

  // ****************
  // state
  // ****************
  prs_st_t st_r, st_nxt;
  logic [7:0] status_r, status_nxt;
  logic por_flag_r, por_flag_nxt;
  logic bod_flag_r, bod_flag_nxt;
  logic por_seq_r;
  logic irq_wake_r;
  logic sleep_cmd_r;
  logic [$clog2(BOD_CYCLES + 1)-1:0] bod_cnt_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic core_reset_n_r;
  logic core_stall_r;
  logic pc_load_r;
  prs_pc_t pc_action_r, pc_action_nxt;

  prs_cnt_if dly_if ();
  prs_cnt_if ost_if ();

  // ****************
  // apb decode
  // ****************
  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  wire setup = psel && !penable && !pready_r;
  wire wr_take = psel && penable && pready_r && pwrite;
  wire hit_stat = hit(paddr, IDX_STATUS);
  wire hit_power_reset_cause = hit(paddr, IDX_POWER_RESET_CAUSE);
  wire hit_ctrl = hit(paddr, IDX_CTRL);
  wire mapped = hit_stat || hit_power_reset_cause || hit_ctrl;
  wire wr_stat = wr_take && hit_stat;
  wire wr_power_reset_cause = wr_take && hit_power_reset_cause;
  wire wr_ctrl = wr_take && hit_ctrl;
  wire [31:0] rd_stat = {24'h0, status_r};
  wire [31:0] rd_power_reset_cause = {30'h0, por_flag_r, bod_flag_r}; // [R13]
  wire [31:0] rd_ctrl = {24'h0, core_stall_r, core_reset_n_r, st_r, 2'h0, sleep_cmd_r};
  wire [31:0] rd_mux = hit_stat ? rd_stat : hit_power_reset_cause ? rd_power_reset_cause : hit_ctrl ? rd_ctrl : 32'h0;

  // ****************
  // supply and pin conditions
  // ****************
  // comparator is qualified only when detection is on
  wire supply_low = brown_out_enable_cfg && brown_out_cmp; // [R7]
  // a dip shorter than the minimum duration never trips
  wire bod_evt = supply_low && (bod_cnt_r == BOD_CYCLES[$bits(bod_cnt_r)-1:0]); // [R8]
  wire pin_low = !external_reset_pin_n;
  wire xtal = (osc_mode == PRS_LP) || (osc_mode == PRS_XT) || (osc_mode == PRS_HS);
  wire dly_en = !delay_timer_disable_cfg; // [R3]
  wire ost_por = xtal && por_seq_r; // [R5]
  wire in_sleep = (st_r == ST_SLEEP);
  wire in_run = (st_r == ST_RUN);
  wire evt_wdt_rst = in_run && wdt_timeout;
  wire evt_wdt_wake = in_sleep && wdt_timeout && !pin_low;
  wire evt_irq_wake = in_sleep && wake_irq && !wdt_timeout && !pin_low;
  wire evt_external_reset_pin_sleep = in_sleep && pin_low;
  wire evt_external_reset_pin_run = in_run && pin_low;
  wire evt_wake = evt_wdt_wake || evt_irq_wake;
  wire sleep_go = in_run && sleep_cmd_r && !pin_low && !wdt_timeout;
  // a crystal wake ends in run too, but it resumes rather than restarts
  wire released = (st_nxt == ST_RUN) && (st_r != ST_RUN) && (st_r != ST_SLEEP) &&
                  (st_r != ST_WAKE);

  // ****************
  // sequencer
  // ****************
  // delays run from the power-on pulse whatever the pin does
  wire prs_st_t after_delays = pin_low ? ST_PIN : ST_RUN; // [R12]

  always_comb begin
    st_nxt = st_r;
    if (por_active || bod_evt) begin
      st_nxt = ST_HOLD; // [R2]
    end else begin
      case (st_r)
        ST_HOLD: begin
          if (!supply_low) begin // [R9]
            if (dly_en) begin
              st_nxt = ST_DELAY; // [R11]
            end else if (ost_por) begin
              st_nxt = ST_OST;
            end else begin
              st_nxt = after_delays; // [R6]
            end
          end
        end
        ST_DELAY: begin
          if (supply_low) begin
            st_nxt = ST_HOLD; // [R10]
          end else if (dly_if.done) begin
            st_nxt = ost_por ? ST_OST : after_delays; // [R4]
          end
        end
        ST_OST: begin
          if (ost_if.done) begin
            st_nxt = after_delays; // [R4]
          end
        end
        ST_PIN: begin
          if (!pin_low) begin
            st_nxt = ST_RUN; // [R12]
          end
        end
        ST_RUN: begin
          if (evt_external_reset_pin_run || evt_wdt_rst) begin
            st_nxt = ST_PIN;
          end else if (sleep_go) begin
            st_nxt = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (evt_external_reset_pin_sleep) begin
            st_nxt = ST_PIN;
          end else if (evt_wake) begin
            st_nxt = xtal ? ST_WAKE : ST_RUN; // [R5]
          end
        end
        ST_WAKE: begin
          if (pin_low) begin
            st_nxt = ST_PIN;
          end else if (ost_if.done) begin
            st_nxt = ST_RUN;
          end
        end
        default: st_nxt = ST_HOLD;
      endcase
    end
  end

  // counters are cleared outside their own phase, so a dip during the delay restarts the delay count
  assign dly_if.clr = (st_r != ST_DELAY); // [R10]
  assign dly_if.tick = 1'b1; // [R1]
  assign ost_if.clr = (st_r != ST_OST) && (st_r != ST_WAKE);
  assign ost_if.tick = osc_tick;

  prs_cnt #(.LIMIT(DELAY_CYCLES)) u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .c(dly_if.cnt)
  ); // [R1]

  prs_cnt #(.LIMIT(OST_CYCLES)) u_ost (
    .pclk(pclk),
    .presetn(presetn),
    .c(ost_if.cnt)
  ); // [R4]

  // ****************
  // program counter action
  // ****************
  always_comb begin
    pc_action_nxt = pc_action_r;
    if (released) begin
      pc_action_nxt = PRS_PC_ZERO; // [R18]
    end else if (st_nxt == ST_RUN && st_r != ST_RUN) begin
      if ((irq_wake_r || evt_irq_wake) && global_irq_enable) begin
        pc_action_nxt = PRS_PC_VEC; // [R18]
      end else begin
        pc_action_nxt = PRS_PC_INC; // [R18]
      end
    end
  end

  // ****************
  // status and cause flags
  // ****************
  // hardware events are applied after the software write, so they win
  always_comb begin
    status_nxt = status_r;
    por_flag_nxt = por_flag_r;
    bod_flag_nxt = bod_flag_r;
    if (wr_stat) begin
      status_nxt = {pwdata[7:5], status_r[TO_BIT], status_r[PD_BIT], pwdata[2:0]};
    end
    if (wr_power_reset_cause) begin
      por_flag_nxt = pwdata[POR_BIT]; // [R15]
      bod_flag_nxt = pwdata[BOD_BIT]; // [R14]
    end
    if (por_active) begin
      status_nxt[7:5] = STAT_HI_RST; // [R19]
      status_nxt[TO_BIT] = 1'b1; // [R17]
      status_nxt[PD_BIT] = 1'b1;
      por_flag_nxt = 1'b0; // [R15]
    end else if (bod_evt) begin
      status_nxt[7:5] = STAT_HI_RST; // [R19]
      status_nxt[TO_BIT] = 1'b1; // [R17]
      status_nxt[PD_BIT] = 1'b1;
      bod_flag_nxt = 1'b0; // [R14]
    end else if (evt_wdt_rst) begin
      status_nxt[7:5] = STAT_HI_RST;
      status_nxt[TO_BIT] = 1'b0; // [R17]
    end else if (evt_wdt_wake) begin
      status_nxt[TO_BIT] = 1'b0; // [R17]
      status_nxt[PD_BIT] = 1'b0;
    end else if (evt_irq_wake) begin
      status_nxt[TO_BIT] = 1'b1;
      status_nxt[PD_BIT] = 1'b0;
    end else if (evt_external_reset_pin_sleep) begin
      status_nxt[7:5] = STAT_HI_RST;
      status_nxt[TO_BIT] = 1'b1; // [R17]
      status_nxt[PD_BIT] = 1'b0;
    end else if (evt_external_reset_pin_run) begin
      status_nxt[7:5] = STAT_HI_RST;
    end
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_HOLD;
      status_r <= {STAT_HI_RST, 2'b11, STAT_LO_RST}; // [R19]
      por_flag_r <= 1'b0;
      bod_flag_r <= POWER_RESET_CAUSE_BOD_RST; // [R16]
      pc_action_r <= PRS_PC_NONE;
    end else begin
      st_r <= st_nxt;
      status_r <= status_nxt;
      por_flag_r <= por_flag_nxt;
      bod_flag_r <= bod_flag_nxt;
      pc_action_r <= pc_action_nxt;
    end
  end

  // only the power-on path may take the start-up count after a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_seq_r <= 1'b1;
    end else if (por_active) begin
      por_seq_r <= 1'b1; // [R21]
    end else if (bod_evt || st_r == ST_RUN) begin
      por_seq_r <= 1'b0; // [R5]
    end
  end

  // qualify the comparator over a run of cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_cnt_r <= '0;
    end else if (!supply_low || bod_evt) begin
      bod_cnt_r <= '0;
    end else begin
      bod_cnt_r <= bod_cnt_r + 1'b1; // [R8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_wake_r <= 1'b0;
      sleep_cmd_r <= 1'b0;
    end else begin
      irq_wake_r <= evt_irq_wake || (irq_wake_r && st_r != ST_RUN && !evt_wdt_wake);
      sleep_cmd_r <= wr_ctrl ? pwdata[SLEEP_BIT] && !sleep_go : sleep_cmd_r && !sleep_go;
    end
  end

  // outputs straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n_r <= 1'b0;
      core_stall_r <= 1'b0;
      pc_load_r <= 1'b0;
    end else begin
      core_reset_n_r <= (st_nxt == ST_RUN) || (st_nxt == ST_SLEEP) || (st_nxt == ST_WAKE); // [R2]
      core_stall_r <= (st_nxt == ST_SLEEP) || (st_nxt == ST_WAKE);
      pc_load_r <= (st_nxt == ST_RUN) && (st_r != ST_RUN); // [R18]
    end
  end

  // zero wait states: answer stands in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core_reset_n = core_reset_n_r;
  assign core_stall = core_stall_r;
  assign pc_load = pc_load_r;
  assign pc_action = pc_action_r;
endmodule // prs_seq

/* File: rtl/prs_pkg.sv */
// constants, types and register map of the power-up reset sequencer
//
// Contract
// [R1] power-on or brown-out starts a 72 ms power-up delay timer
// [R2] core stays in reset while the power-up delay runs
// [R3] delay timer disable config bit set means no power-up delay
// [R4] after the delay, 1024 oscillator cycles are counted before release
// [R5] start-up count only in crystal modes, after power-on or wake
// [R6] rc, external and internal clock modes: delay only, or none
// [R7] brown-out enable config bit turns brown-out detection on
// [R8] supply below threshold longer than minimum duration resets device
// [R9] reset held until supply above level, then optional 72 ms delay
// [R10] supply dip during delay restarts the delay after recovery
// [R11] delay starts when power-on pulse ends, start-up count after it
// [R12] delays ignore reset pin; pin released late starts execution at once
// [R13] power reset cause register: bit 0 brown-out, bit 1 power-on
// [R14] brown-out flag cleared by brown-out reset, software sets it
// [R15] power-on flag cleared by power-on reset only, software sets it
// [R16] brown-out flag is undefined while detection is disabled
// [R17] timeout and powerdown bits set per reset or wake cause
// [R18] resets load pc 000h, wakes resume pc+1, irq wake vectors 0004h (code vectors only with global_irq_enable set, else pc+1)
// [R19] status resets to 0001 1xxx, cause register 0x or 10
// [R20] configuration should enable the delay when brown-out is enabled
// [R21] falling supply alone never causes a power-on reset
// [R22] delay and start-up count are parameterised cycle counters
package prs_pkg;
  // ****************
  // timing
  // ****************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DLY_MS = 72;
  localparam int unsigned DLY_CYC = DLY_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_CYC = 1024;
  localparam int unsigned BOD_MIN_NS = 100;
  localparam int unsigned BOD_MIN_CYC = (BOD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // ****************
  // register indices, byte address is four times the index
  // ****************
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_POWER_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam int unsigned AW = 10;
  // ****************
  // fields and reset values
  // ****************
  localparam int unsigned TO_BIT = 4;
  localparam int unsigned PD_BIT = 3;
  localparam int unsigned POR_BIT = 1;
  localparam int unsigned BOD_BIT = 0;
  localparam int unsigned SLEEP_BIT = 0;
  localparam logic [2:0] STAT_HI_RST = 3'h0;
  localparam logic [2:0] STAT_LO_RST = 3'h0;
  localparam logic POWER_RESET_CAUSE_BOD_RST = 1'b1;
  localparam logic [1:0] PC_ZERO = 2'h0;
  localparam logic [15:0] PC_VEC = 16'h0004;
  // ****************
  // types
  // ****************
  typedef enum logic [2:0] {
    PRS_LP = 3'b000, PRS_XT = 3'b001, PRS_HS = 3'b010,
    PRS_EC = 3'b011, PRS_RC = 3'b100, PRS_INTERNAL_RC_CLOCK_MODE = 3'b101
  } prs_osc_t;
  typedef enum logic [1:0] {
    PRS_PC_NONE = 2'b00, PRS_PC_ZERO = 2'b01, PRS_PC_INC = 2'b10, PRS_PC_VEC = 2'b11
  } prs_pc_t;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000, ST_DELAY = 3'b001, ST_OST = 3'b010, ST_PIN = 3'b011,
    ST_RUN = 3'b100, ST_SLEEP = 3'b101, ST_WAKE = 3'b110
  } prs_st_t;
endpackage

/* File: rtl/prs_cnt_if.sv */
// carrier between the sequencer and one of its cycle counters
`timescale 1ns/10ps
interface prs_cnt_if;
  logic clr;
  logic tick;
  logic done;
  modport owner (output clr, output tick, input done);
  modport cnt (input clr, input tick, output done);
endinterface

/* File: rtl/prs_cnt.sv */
// parameterised tick counter with sticky done flag
`timescale 1ns/10ps
module prs_cnt #(
  parameter int unsigned LIMIT = 1024,
  parameter int unsigned W = $clog2(LIMIT + 1)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  prs_cnt_if.cnt c
);
  logic [W-1:0] cnt_r;
  logic done_r;
  wire last = (cnt_r == W'(LIMIT - 1));

  // [R22]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (c.clr) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else if (c.tick && !done_r) begin
      cnt_r <= cnt_r + W'(1);
      done_r <= last;
    end
  end

  assign c.done = done_r;
endmodule // prs_cnt

/* File: verif/prs_seq_chk.sv */
// port assertions for the power-up reset sequencer
`timescale 1ns/10ps
module prs_seq_chk #(
  parameter int unsigned DELAY_CYCLES = 20,
  parameter int unsigned BOD_CYCLES = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [prs_pkg::AW-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // supply, pins, configuration
  input wire logic por_active,
  input wire logic brown_out_cmp,
  input wire logic external_reset_pin_n,
  input wire logic brown_out_enable_cfg,
  input wire logic delay_timer_disable_cfg,
  input wire logic wdt_timeout,
  // core control
  input wire logic core_reset_n,
  input wire logic pc_load,
  input wire prs_pkg::prs_pc_t pc_action
);
  import prs_pkg::*;
  // ***
  // helpers
  // ***
  logic [7:0] bod_run_r;
  logic [15:0] quiet_r;
  logic [3:0] cause_r;
  wire logic dip = brown_out_enable_cfg & brown_out_cmp;
  wire logic cause = por_active | dip | ~external_reset_pin_n | wdt_timeout;
  wire logic mapped = (paddr == 10'h00c) | (paddr == 10'h238) | (paddr == 10'h100);
  // saturate so a long run never wraps back to a small count
  wire logic [7:0] bod_run_nxt = !dip ? 8'h00 : bod_run_r + {7'h00, ~&bod_run_r};
  wire logic [15:0] quiet_nxt = (por_active | dip) ? 16'h0000 : quiet_r + {15'h0, ~&quiet_r};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_run_r <= 8'h00;
      quiet_r <= 16'h0000;
      cause_r <= 4'h0;
    end else begin
      bod_run_r <= bod_run_nxt;
      quiet_r <= quiet_nxt;
      cause_r <= {cause_r[2:0], cause};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_por_hold; por_active ##1 por_active |=> !core_reset_n; endproperty
  property p_delay_min; $rose(core_reset_n) |-> delay_timer_disable_cfg || quiet_r >= DELAY_CYCLES;
  endproperty
  property p_rel_pc; $rose(core_reset_n) |-> pc_load && pc_action == PRS_PC_ZERO; endproperty
  property p_bod; bod_run_r >= BOD_CYCLES + 4 |-> !core_reset_n; endproperty
  property p_fall_cause; $fell(core_reset_n) |-> (|cause_r) || cause; endproperty
  property p_pin; !external_reset_pin_n [*4] |-> !core_reset_n; endproperty
  property p_apb_ready; psel && !penable |=> pready ##1 !pready; endproperty
  property p_apb_err; pready |-> pslverr == !mapped; endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("core ran during power-on pulse");
  a_delay_min: assert property (p_delay_min)
    else $error("release before power-up delay ran out");
  a_rel_pc: assert property (p_rel_pc)
    else $error("release without pc load of zero");
  a_bod: assert property (p_bod)
    else $error("long brown-out did not reset");
  a_fall_cause: assert property (p_fall_cause)
    else $error("reset without a cause");
  a_pin: assert property (p_pin)
    else $error("reset pin low but core running");
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb ready not a single access cycle");
  a_apb_err: assert property (p_apb_err)
    else $error("apb error flag wrong for address");
  c_release: cover property ($rose(core_reset_n));
  c_bod: cover property (bod_run_r == BOD_CYCLES + 4);
  c_err: cover property (pready && pslverr);
endmodule // prs_seq_chk
bind prs_seq prs_seq_chk #(.DELAY_CYCLES(DELAY_CYCLES), .BOD_CYCLES(BOD_CYCLES)) i_prs_seq_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .por_active(por_active), .brown_out_cmp(brown_out_cmp),
  .external_reset_pin_n(external_reset_pin_n), .brown_out_enable_cfg(brown_out_enable_cfg),
  .delay_timer_disable_cfg(delay_timer_disable_cfg), .wdt_timeout(wdt_timeout),
  .core_reset_n(core_reset_n), .pc_load(pc_load), .pc_action(pc_action));

/* File: verif/test_prs_seq.sv */
// self-checking random bench for the power-up reset sequencer
`timescale 1ns/10ps
`define TB_CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, got, exp); end end
module test_prs_seq;
  import prs_pkg::*;
  localparam int DLY = 20;
  localparam int OSTC = 8;
  localparam int BODC = 3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, r, d;
  logic por_active, brown_out_cmp, external_reset_pin_n, osc_tick;
  prs_osc_t osc_mode;
  logic delay_timer_disable_cfg, brown_out_enable_cfg, wdt_timeout, wake_irq, global_irq_enable;
  logic core_reset_n, core_stall, pc_load;
  prs_pc_t pc_action;
  int fail_count, n_tests, seed, n, ticks;
  prs_seq #(.DELAY_CYCLES(DLY), .OST_CYCLES(OSTC), .BOD_CYCLES(BODC)) i_prs_seq (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ***
  // tasks and expectations
  // ***
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] dw);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) begin
      fail_count++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rel(input int k);
    n = 0;
    while (core_reset_n !== 1'b1 && n < k) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic wait_pc;
    n = 0;
    while (pc_load !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    // a missing load pulse would leave a stale action to compare
    if (pc_load !== 1'b1) begin
      fail_count++;
    end
  endtask
  task automatic por_pulse;
    @(posedge pclk);
    por_active <= 1'b1;
    cyc(3);
    por_active <= 1'b0;
  endtask
  // wake kinds: 0 watchdog, 1 irq, 2 irq with global enable, 3 reset pin
  function automatic prs_pc_t pc_of(input int k);
    return k == 3 ? PRS_PC_ZERO : (k == 2 ? PRS_PC_VEC : PRS_PC_INC);
  endfunction
  function automatic logic [1:0] tp_of(input int k);
    return k == 0 ? 2'b00 : 2'b10;
  endfunction
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    cyc(20000);
    fail_count++;
    give_verdict;
  end
  initial begin
    seed = 66995;
    {psel, penable, pwrite, paddr, pwdata, fail_count, n_tests} = '0;
    {presetn, por_active, brown_out_cmp, osc_tick, wdt_timeout, wake_irq} = '0;
    {delay_timer_disable_cfg, global_irq_enable} = '0;
    {external_reset_pin_n, brown_out_enable_cfg} = 2'b11;
    osc_mode = PRS_RC;
    cyc(3);
    presetn <= 1'b1;
    apb(0, 10'h00c, 0);
    `TB_CHK(r, 32'h18)
    apb(0, 10'h238, 0);
    `TB_CHK(r, 32'h1)
    wait_rel(DLY + 40);
    // every oscillator mode, delay on and off; crystal waits for ticks
    for (int m = 0; m < 6; m++) begin
      for (int dd = 0; dd < 2; dd++) begin
        osc_mode <= prs_osc_t'(m);
        delay_timer_disable_cfg <= dd[0];
        brown_out_enable_cfg <= !dd[0];
        por_pulse();
        wait_rel(DLY + 40);
        if (m < 3) begin
          `TB_CHK(core_reset_n, 1'b0)
          ticks = 0;
          // drive before the edge so the tick is never assigned twice in one step
          while (core_reset_n !== 1'b1 && ticks < OSTC + 40) begin
            osc_tick <= $random(seed);
            @(posedge pclk);
            ticks += osc_tick;
          end
          `TB_CHK(ticks >= OSTC && ticks <= OSTC + 3, 1'b1)
          osc_tick <= 1'b0;
        end else begin
          `TB_CHK(n >= (dd ? 0 : DLY) && n <= (dd ? 4 : DLY + 4), 1'b1)
        end
        apb(0, 10'h238, 0);
        `TB_CHK(r[1], 1'b0)
        apb(1, 10'h238, 32'h3);
      end
    end
    // pin held low across the power-up delay, then released late
    brown_out_enable_cfg <= 1'b1;
    delay_timer_disable_cfg <= 1'b0;
    external_reset_pin_n <= 1'b0;
    por_pulse();
    cyc(DLY + 20);
    `TB_CHK(core_reset_n, 1'b0)
    external_reset_pin_n <= 1'b1;
    wait_rel(4);
    `TB_CHK(core_reset_n, 1'b1)
    // software marks both flags after power-on so a brown-out shows up
    apb(1, 10'h238, 32'h3);
    // qualified brown-out, then a dip in mid-delay restarts it
    brown_out_cmp <= 1'b1;
    cyc(BODC + 6);
    `TB_CHK(core_reset_n, 1'b0)
    apb(0, 10'h238, 0);
    `TB_CHK(r, 32'h2)
    apb(0, 10'h00c, 0);
    `TB_CHK(r[4:3], 2'b11)
    brown_out_cmp <= 1'b0;
    cyc(10);
    brown_out_cmp <= 1'b1;
    cyc(1);
    brown_out_cmp <= 1'b0;
    wait_rel(DLY + 40);
    `TB_CHK(n >= DLY && n <= DLY + 4, 1'b1)
    // short dip, then a long one with detection off: no reset
    brown_out_cmp <= 1'b1;
    cyc(BODC - 1);
    brown_out_cmp <= 1'b0;
    cyc(3);
    `TB_CHK(core_reset_n, 1'b1)
    brown_out_enable_cfg <= 1'b0;
    brown_out_cmp <= 1'b1;
    cyc(20);
    `TB_CHK(core_reset_n, 1'b1)
    brown_out_cmp <= 1'b0;
    brown_out_enable_cfg <= 1'b1;
    cyc(DLY + 10);
    // status: software bits writable, timeout and powerdown read-only
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      apb(1, 10'h00c, d);
      apb(0, 10'h00c, 0);
      `TB_CHK(r, {24'h0, d[7:5], 2'b11, d[2:0]})
    end
    // pin reset and watchdog reset while running
    external_reset_pin_n <= 1'b0;
    cyc(5);
    `TB_CHK(core_reset_n, 1'b0)
    external_reset_pin_n <= 1'b1;
    wait_pc();
    `TB_CHK(pc_action, PRS_PC_ZERO)
    apb(0, 10'h00c, 0);
    `TB_CHK(r[4:3], 2'b11)
    wdt_timeout <= 1'b1;
    cyc(1);
    wdt_timeout <= 1'b0;
    wait_pc();
    `TB_CHK(pc_action, PRS_PC_ZERO)
    apb(0, 10'h00c, 0);
    `TB_CHK(r[4:3], 2'b01)
    // sleep and each kind of wake
    for (int k = 0; k < 4; k++) begin
      apb(1, 10'h100, 32'h1);
      cyc(3);
      `TB_CHK(core_stall, 1'b1)
      global_irq_enable <= (k == 2);
      wdt_timeout <= (k == 0);
      wake_irq <= (k == 1 || k == 2);
      external_reset_pin_n <= (k != 3);
      cyc(k == 3 ? 5 : 1);
      {wdt_timeout, wake_irq, external_reset_pin_n} <= 3'b001;
      wait_pc();
      `TB_CHK(pc_action, pc_of(k))
      apb(0, 10'h00c, 0);
      `TB_CHK(r[4:3], tp_of(k))
    end
    // crystal wake holds the core stalled until the start-up count ends
    osc_mode <= PRS_XT;
    global_irq_enable <= 1'b0;
    apb(1, 10'h100, 32'h1);
    cyc(3);
    wdt_timeout <= 1'b1;
    cyc(1);
    wdt_timeout <= 1'b0;
    cyc(3);
    `TB_CHK(core_stall, 1'b1)
    `TB_CHK(core_reset_n, 1'b1)
    repeat (OSTC) begin
      osc_tick <= 1'b1;
      cyc(1);
    end
    osc_tick <= 1'b0;
    wait_pc();
    `TB_CHK(pc_action, PRS_PC_INC)
    apb(0, 10'h00c, 0);
    `TB_CHK(r[4:3], 2'b00)
    // unmapped address refused
    apb(1, 10'h004, 32'hff);
    `TB_CHK(e, 1'b1)
    apb(0, 10'h004, 0);
    `TB_CHK(r, 32'h0)
    give_verdict();
  end
endmodule // test_prs_seq
